// File: core/usc_pkg.sv
// usc_pkg: constants and carrier types of the uart shadow control register block
// assumes a 50 MHz MCLK and an AHB-Lite bus with 32-bit data, single word transfers
`default_nettype none
package usc_pkg;

  // clock and timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned IR_PERIOD_NS  = 1600;
  localparam int unsigned IR_LOW_NS     = 120;
  localparam int unsigned IR_CNT_W      = 7;
  localparam logic [IR_CNT_W-1:0] IR_PERIOD_CYC = IR_CNT_W'(IR_PERIOD_NS / CLK_PERIOD_NS);
  localparam logic [IR_CNT_W-1:0] IR_LOW_CYC    = IR_CNT_W'((IR_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // register byte addresses
  localparam logic [31:0] ADDR_FCR        = 32'h5000_1008;
  localparam logic [31:0] ADDR_LCR        = 32'h5000_100C;
  localparam logic [31:0] ADDR_MCR        = 32'h5000_1010;
  localparam logic [31:0] ADDR_BREAK      = 32'h5000_1090;
  localparam logic [31:0] ADDR_DMA        = 32'h5000_1094;
  localparam logic [31:0] ADDR_FEN        = 32'h5000_1098;
  localparam logic [31:0] ADDR_TRIG       = 32'h5000_109C;
  localparam logic [31:0] ADDR_INT_STATUS = 32'h5000_10C0;
  localparam logic [31:0] ADDR_INT_MASK   = 32'h5000_10C4;

  // field positions
  localparam int unsigned LCR_BREAK_BIT = 6;
  localparam int unsigned MCR_LOOP_BIT  = 4;
  localparam int unsigned MCR_IR_BIT    = 6;
  localparam int unsigned FCR_EN_BIT    = 0;
  localparam int unsigned FCR_RXRST_BIT = 1;
  localparam int unsigned FCR_TXRST_BIT = 2;
  localparam int unsigned FCR_DMA_BIT   = 3;
  localparam int unsigned FCR_TRIG_LSB  = 6;
  localparam int unsigned EV_W          = 3;
  localparam int unsigned EV_BREAK      = 0;
  localparam int unsigned EV_FIFO_RESET = 1;
  localparam int unsigned EV_RX_TRIG    = 2;

  // reset values and the fifo control store mask
  localparam logic [7:0]      LCR_RESET  = 8'h00;
  localparam logic [7:0]      FCR_RESET  = 8'h00;
  localparam logic [7:0]      MCR_RESET  = 8'h00;
  localparam logic [7:0]      FCR_STORE  = 8'hF9;
  localparam logic [EV_W-1:0] MASK_RESET = 3'h0;

  typedef enum logic [1:0] {TRIG_ONE, TRIG_QUARTER, TRIG_HALF, TRIG_TWO_LESS} usc_trig_t;
  typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ} usc_bus_t;
  typedef enum logic [3:0] {SEL_NONE, SEL_BREAK, SEL_DMA, SEL_FEN, SEL_TRIG, SEL_LCR, SEL_FCR,
                            SEL_MCR, SEL_STAT, SEL_MASK} usc_sel_t;

  typedef struct packed {
    logic tx_line;
    logic ir_tx_n;
    logic loop_rx;
  } usc_line_t;

  typedef struct packed {
    logic [7:0]          line_control_register;
    logic [7:0]          fifo_control_register;
    logic [7:0]          modem_control_register;
    logic [EV_W-1:0]     int_stat;
    logic [EV_W-1:0]     int_mask;
    usc_bus_t            bus;
    usc_sel_t            sel;
    logic [31:0]         hrdata;
    logic                hready;
    logic                irq;
    usc_line_t           line;
    logic                dma_rx_n;
    logic                dma_tx_n;
    logic                fifo_reset;
    logic                rx_avail;
    logic [IR_CNT_W-1:0] ir_cnt;
  } usc_state_t;

endpackage
`default_nettype wire

// File: core/usc_trig_decode.sv
// usc_trig_decode: turns the receive trigger field into a fill threshold
// assumes the fill level comes from fifo logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module usc_trig_decode #(
  parameter int unsigned DEPTH = 16,
  parameter int unsigned LVL_W = 5
) (
  // control
  input  wire usc_pkg::usc_trig_t trig,
  input  wire logic               fifo_en,
  // fill level
  input  wire logic [LVL_W-1:0]   level,
  output logic      [LVL_W-1:0]   threshold,
  output logic                    reached
);

  always_comb
  begin
    case (trig)
      usc_pkg::TRIG_ONE:     threshold = LVL_W'(1);
      usc_pkg::TRIG_QUARTER: threshold = LVL_W'(DEPTH / 4);
      usc_pkg::TRIG_HALF:    threshold = LVL_W'(DEPTH / 2);
      default:               threshold = LVL_W'(DEPTH - 2);
    endcase
  end

  // with the fifo off the receiver holds one character, so any data counts
  assign reached = fifo_en ? (level >= threshold) : (level != '0);
endmodule
`default_nettype wire

// File: core/usc_line_drive.sv
// usc_line_drive: next value of the serial, infrared and loopback lines
// assumes tx_data is the transmitter's serial bit on the same clock
`timescale 1ns/1ps
`default_nettype none
module usc_line_drive (
  // control
  input  wire logic                          brk,
  input  wire logic                          loop,
  input  wire logic                          ir,
  input  wire logic [usc_pkg::IR_CNT_W-1:0]  ir_cnt,
  // data
  input  wire logic                          tx_data,
  output usc_pkg::usc_line_t                 line
);

  always_comb
  begin
    line.tx_line = 1'b1;
    line.ir_tx_n = 1'b1;
    line.loop_rx = 1'b1;
    if (loop)
    begin
      // external line stays marking, break goes to the own receiver
      line.loop_rx = brk ? 1'b0 : tx_data;
    end
    else
    begin
      line.tx_line = brk ? 1'b0 : tx_data;
      if (ir)
      begin
        line.ir_tx_n = brk ? (ir_cnt >= usc_pkg::IR_LOW_CYC) : tx_data;
      end
    end
  end
endmodule
`default_nettype wire

// File: core/usc_shadow_ctrl.sv
// usc_shadow_ctrl: uart shadow control registers with AHB-Lite slave, break, dma and irq
// assumes one AHB-Lite master, single word transfers; fifo status inputs on MCLK
//
// Overview of operation
// - break alias write sets line control break bit 6 directly
// - break set outside loopback drives serial transmit output to spacing level 0
// - outside loopback, transmit line stays low until break cleared
// - outside loopback, infrared mode with break pulses infrared output continuously
// - loopback routes break to own receiver, not the external line
// - dma alias mirrors fifo control bit 3, selects dma mode 0 or 1
// - shadow fifo field write changes only that field
// - fifo enable alias mirrors fifo control bit 0, enables both fifos
// - clearing fifo enable after set resets both fifo controllers
// - receive trigger alias mirrors fifo control bits 7:6
// - trigger 00 one char, 01 quarter, 10 half, 11 two below full
// - dma mode 1 uses trigger level for active-low receive dma request
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ps
`default_nettype none
module usc_shadow_ctrl #(
  parameter int unsigned DEPTH = 16,
  parameter int unsigned LVL_W = $clog2(DEPTH) + 1
) (
  // clock and reset
  input  wire logic             MCLK,
  input  wire logic             ARST_N,
  // ahb-lite slave
  input  wire logic             HSEL,
  input  wire logic [31:0]      HADDR,
  input  wire logic [1:0]       HTRANS,
  input  wire logic             HWRITE,
  input  wire logic [2:0]       HSIZE,
  input  wire logic [31:0]      HWDATA,
  input  wire logic             HREADY,
  output logic                  HREADYOUT,
  output logic                  HRESP,
  output logic      [31:0]      HRDATA,
  // serial line
  input  wire logic             TX_DATA,
  output logic                  TX_LINE,
  output logic                  IR_TX_N,
  output logic                  LOOP_RX,
  // fifo and dma
  input  wire logic [LVL_W-1:0] RX_LEVEL,
  input  wire logic             TX_EMPTY,
  input  wire logic             TX_FULL,
  output logic                  FIFO_ENABLE,
  output logic                  FIFO_RESET,
  output logic                  DMA_MODE,
  output logic                  RX_AVAIL,
  output logic                  DMA_RX_REQ_N,
  output logic                  DMA_TX_REQ_N,
  // interrupt
  output logic                  IRQ
);

  localparam usc_pkg::usc_state_t STATE_RESET = '{
    line_control_register:        usc_pkg::LCR_RESET,
    fifo_control_register:        usc_pkg::FCR_RESET,
    modem_control_register:        usc_pkg::MCR_RESET,
    int_stat:   '0,
    int_mask:   usc_pkg::MASK_RESET,
    bus:        usc_pkg::BUS_IDLE,
    sel:        usc_pkg::SEL_NONE,
    hrdata:     '0,
    hready:     1'b1,
    irq:        1'b0,
    line:       '{tx_line: 1'b1, ir_tx_n: 1'b1, loop_rx: 1'b1},
    dma_rx_n:   1'b1,
    dma_tx_n:   1'b1,
    fifo_reset: 1'b0,
    rx_avail:   1'b0,
    ir_cnt:     '0
  };

  usc_pkg::usc_state_t     s;
  usc_pkg::usc_state_t     next_s;
  usc_pkg::usc_line_t      line_now;
  logic [LVL_W-1:0]        threshold;
  logic                    reached;
  logic [usc_pkg::EV_W-1:0] ev;
  logic [usc_pkg::EV_W-1:0] clr;
  logic                    brk;
  logic                    loop;
  logic                    ir;

  assign brk  = s.line_control_register[usc_pkg::LCR_BREAK_BIT];
  assign loop = s.modem_control_register[usc_pkg::MCR_LOOP_BIT];
  assign ir   = s.modem_control_register[usc_pkg::MCR_IR_BIT];

  function automatic usc_pkg::usc_sel_t decode_sel(input logic [31:0] addr);
    case (addr)
      usc_pkg::ADDR_BREAK:      return usc_pkg::SEL_BREAK;
      usc_pkg::ADDR_DMA:        return usc_pkg::SEL_DMA;
      usc_pkg::ADDR_FEN:        return usc_pkg::SEL_FEN;
      usc_pkg::ADDR_TRIG:       return usc_pkg::SEL_TRIG;
      usc_pkg::ADDR_LCR:        return usc_pkg::SEL_LCR;
      usc_pkg::ADDR_FCR:        return usc_pkg::SEL_FCR;
      usc_pkg::ADDR_MCR:        return usc_pkg::SEL_MCR;
      usc_pkg::ADDR_INT_STATUS: return usc_pkg::SEL_STAT;
      usc_pkg::ADDR_INT_MASK:   return usc_pkg::SEL_MASK;
      default:                  return usc_pkg::SEL_NONE;
    endcase
  endfunction

  // unmapped addresses read zero, reserved bits read zero
  function automatic logic [31:0] read_word(input usc_pkg::usc_state_t st);
    logic [31:0] w;
    w = '0;
    case (st.sel)
      usc_pkg::SEL_BREAK: w[0]   = st.line_control_register[usc_pkg::LCR_BREAK_BIT];
      usc_pkg::SEL_DMA:   w[0]   = st.fifo_control_register[usc_pkg::FCR_DMA_BIT];
      usc_pkg::SEL_FEN:   w[0]   = st.fifo_control_register[usc_pkg::FCR_EN_BIT];
      usc_pkg::SEL_TRIG:  w[1:0] = st.fifo_control_register[usc_pkg::FCR_TRIG_LSB +: 2];
      usc_pkg::SEL_LCR:   w[7:0] = st.line_control_register;
      usc_pkg::SEL_FCR:   w[7:0] = st.fifo_control_register;
      usc_pkg::SEL_MCR:   w[7:0] = st.modem_control_register;
      usc_pkg::SEL_STAT:  w[usc_pkg::EV_W-1:0] = st.int_stat;
      usc_pkg::SEL_MASK:  w[usc_pkg::EV_W-1:0] = st.int_mask;
      default:            w = '0;
    endcase
    return w;
  endfunction

  usc_trig_decode #(
    .DEPTH (DEPTH),
    .LVL_W (LVL_W)
  ) u_trig (
    .trig      (usc_pkg::usc_trig_t'(s.fifo_control_register[usc_pkg::FCR_TRIG_LSB +: 2])),
    .fifo_en   (s.fifo_control_register[usc_pkg::FCR_EN_BIT]),
    .level     (RX_LEVEL),
    .threshold (threshold),
    .reached   (reached)
  );

  usc_line_drive u_line (
    .brk     (brk),
    .loop    (loop),
    .ir      (ir),
    .ir_cnt  (s.ir_cnt),
    .tx_data (TX_DATA),
    .line    (line_now)
  );

  always_comb
  begin
    next_s            = s;
    next_s.fifo_reset = 1'b0;
    ev                = '0;
    clr               = '0;
    // write data phase: each alias touches only its own field
    if (s.bus == usc_pkg::BUS_WRITE)
    begin
      case (s.sel)
        usc_pkg::SEL_BREAK: next_s.line_control_register[usc_pkg::LCR_BREAK_BIT]      = HWDATA[0];
        usc_pkg::SEL_DMA:   next_s.fifo_control_register[usc_pkg::FCR_DMA_BIT]        = HWDATA[0];
        usc_pkg::SEL_FEN:   next_s.fifo_control_register[usc_pkg::FCR_EN_BIT]         = HWDATA[0];
        usc_pkg::SEL_TRIG:  next_s.fifo_control_register[usc_pkg::FCR_TRIG_LSB +: 2]  = HWDATA[1:0];
        usc_pkg::SEL_LCR:   next_s.line_control_register = HWDATA[7:0];
        usc_pkg::SEL_FCR:
        begin
          // the two fifo reset bits are self-clearing, never stored
          next_s.fifo_control_register = HWDATA[7:0] & usc_pkg::FCR_STORE;
          next_s.fifo_reset = HWDATA[usc_pkg::FCR_RXRST_BIT] | HWDATA[usc_pkg::FCR_TXRST_BIT];
        end
        usc_pkg::SEL_MCR:   next_s.modem_control_register = HWDATA[7:0];
        usc_pkg::SEL_MASK:  next_s.int_mask = HWDATA[usc_pkg::EV_W-1:0];
        usc_pkg::SEL_STAT:  clr = HWDATA[usc_pkg::EV_W-1:0];
        default:            next_s.int_mask = s.int_mask;
      endcase
    end
    // enable falling from one to zero resets both fifo controllers
    if (s.fifo_control_register[usc_pkg::FCR_EN_BIT] && !next_s.fifo_control_register[usc_pkg::FCR_EN_BIT])
    begin
      next_s.fifo_reset = 1'b1;
    end
    ev[usc_pkg::EV_FIFO_RESET] = next_s.fifo_reset;
    ev[usc_pkg::EV_BREAK]      = !brk && next_s.line_control_register[usc_pkg::LCR_BREAK_BIT];
    next_s.rx_avail            = reached;
    ev[usc_pkg::EV_RX_TRIG]    = reached && !s.rx_avail;
    // an event in the clearing cycle survives the clear
    next_s.int_stat = (s.int_stat & ~clr) | ev;
    next_s.irq      = |(next_s.int_stat & next_s.int_mask);

    // receive dma: mode 1 waits for the trigger level and holds until empty
    if (!s.fifo_control_register[usc_pkg::FCR_DMA_BIT] || !s.fifo_control_register[usc_pkg::FCR_EN_BIT])
    begin
      next_s.dma_rx_n = (RX_LEVEL == '0);
    end
    else if (reached)
    begin
      next_s.dma_rx_n = 1'b0;
    end
    else if (RX_LEVEL == '0)
    begin
      next_s.dma_rx_n = 1'b1;
    end
    // transmit dma: mode 1 asks from empty until full
    if (!s.fifo_control_register[usc_pkg::FCR_DMA_BIT] || !s.fifo_control_register[usc_pkg::FCR_EN_BIT])
    begin
      next_s.dma_tx_n = !TX_EMPTY;
    end
    else if (TX_EMPTY)
    begin
      next_s.dma_tx_n = 1'b0;
    end
    else if (TX_FULL)
    begin
      next_s.dma_tx_n = 1'b1;
    end

    // infrared break pulse counter, idle at zero outside a break
    if (brk && ir && !loop)
    begin
      next_s.ir_cnt = (s.ir_cnt == usc_pkg::IR_PERIOD_CYC - 1'b1) ? '0 : s.ir_cnt + 1'b1;
    end
    else
    begin
      next_s.ir_cnt = '0;
    end
    next_s.line = line_now;

    // bus: writes take no wait state, reads take one so a write just before is seen
    case (s.bus)
      usc_pkg::BUS_READ:
      begin
        next_s.hrdata = read_word(s);
        next_s.hready = 1'b1;
        next_s.bus    = usc_pkg::BUS_IDLE;
      end
      usc_pkg::BUS_IDLE, usc_pkg::BUS_WRITE:
      begin
        next_s.bus = usc_pkg::BUS_IDLE;
        if (HSEL && HTRANS[1] && HREADY)
        begin
          next_s.sel    = decode_sel(HADDR);
          next_s.bus    = HWRITE ? usc_pkg::BUS_WRITE : usc_pkg::BUS_READ;
          next_s.hready = HWRITE;
        end
      end
      default:
      begin
        next_s.bus    = usc_pkg::BUS_IDLE;
        next_s.hready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      s <= STATE_RESET;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign HREADYOUT    = s.hready;
  assign HRESP        = 1'b0;
  assign HRDATA       = s.hrdata;
  assign TX_LINE      = s.line.tx_line;
  assign IR_TX_N      = s.line.ir_tx_n;
  assign LOOP_RX      = s.line.loop_rx;
  assign FIFO_ENABLE  = s.fifo_control_register[usc_pkg::FCR_EN_BIT];
  assign FIFO_RESET   = s.fifo_reset;
  assign DMA_MODE     = s.fifo_control_register[usc_pkg::FCR_DMA_BIT];
  assign RX_AVAIL     = s.rx_avail;
  assign DMA_RX_REQ_N = s.dma_rx_n;
  assign DMA_TX_REQ_N = s.dma_tx_n;
  assign IRQ          = s.irq;

  // checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!ARST_N);

  a_break_alias_write: assert property (
    s.bus == usc_pkg::BUS_WRITE && s.sel == usc_pkg::SEL_BREAK
    |=> s.line_control_register[usc_pkg::LCR_BREAK_BIT] == $past(HWDATA[0]) && s.line_control_register[5:0] == $past(s.line_control_register[5:0]))
    else $error("break alias write did not reach line control bit 6");

  a_break_line_low: assert property (
    brk && !loop |=> !TX_LINE)
    else $error("transmit line not at spacing level during break");

  a_break_held_low: assert property (
    brk && !loop ##1 brk && !loop |=> !TX_LINE && !$past(TX_LINE))
    else $error("transmit line released while break still set");

  a_ir_break_pulse: assert property (
    brk && ir && !loop && s.ir_cnt == '0 |=> !IR_TX_N ##[1:6] !brk || !ir || loop || IR_TX_N)
    else $error("infrared output not pulsing during break");

  a_loop_break_inside: assert property (
    brk && loop |=> TX_LINE && !LOOP_RX)
    else $error("loopback break leaked onto external line");

  a_dma_alias_only: assert property (
    s.bus == usc_pkg::BUS_WRITE && s.sel == usc_pkg::SEL_DMA
    |=> DMA_MODE == $past(HWDATA[0]) && s.fifo_control_register[7:4] == $past(s.fifo_control_register[7:4]) && s.fifo_control_register[2:0] == $past(s.fifo_control_register[2:0]))
    else $error("dma alias write disturbed other fifo control fields");

  a_fen_alias_write: assert property (
    s.bus == usc_pkg::BUS_WRITE && s.sel == usc_pkg::SEL_FEN |=> FIFO_ENABLE == $past(HWDATA[0]))
    else $error("fifo enable alias write not mirrored");

  a_fifo_reset_pulse: assert property (
    $fell(s.fifo_control_register[usc_pkg::FCR_EN_BIT]) |-> FIFO_RESET)
    else $error("disabling fifos did not reset the controllers");

  a_trig_alias_write: assert property (
    s.bus == usc_pkg::BUS_WRITE && s.sel == usc_pkg::SEL_TRIG
    |=> s.fifo_control_register[usc_pkg::FCR_TRIG_LSB +: 2] == $past(HWDATA[1:0]) && s.fifo_control_register[5:0] == $past(s.fifo_control_register[5:0]))
    else $error("trigger alias write not mirrored");

  a_trig_decode_map: assert property (
    (s.fifo_control_register[7:6] == 2'h0 |-> threshold == LVL_W'(1)) and
    (s.fifo_control_register[7:6] == 2'h1 |-> threshold == LVL_W'(DEPTH / 4)) and
    (s.fifo_control_register[7:6] == 2'h2 |-> threshold == LVL_W'(DEPTH / 2)) and
    (s.fifo_control_register[7:6] == 2'h3 |-> threshold == LVL_W'(DEPTH - 2)))
    else $error("receive trigger decodes to a wrong level");

  a_dma_rx_trigger: assert property (
    s.fifo_control_register[usc_pkg::FCR_DMA_BIT] && s.fifo_control_register[usc_pkg::FCR_EN_BIT] && RX_LEVEL >= threshold |=> !DMA_RX_REQ_N)
    else $error("receive dma request missing at trigger level");

  a_alias_read_back: assert property (
    s.bus == usc_pkg::BUS_READ && s.sel == usc_pkg::SEL_TRIG
    |=> HREADYOUT && HRDATA[31:2] == '0 && HRDATA[1:0] == $past(s.fifo_control_register[7:6]))
    else $error("trigger alias read returned wrong value");

  a_irq_follows: assert property (
    |(s.int_stat & s.int_mask) |-> IRQ)
    else $error("interrupt output low with unmasked status set");

  a_break_event_flag: assert property (
    $rose(brk) |-> s.int_stat[usc_pkg::EV_BREAK])
    else $error("break start did not set its status bit");

  c_ir_break:    cover property (brk && ir && !loop ##1 !IR_TX_N ##1 IR_TX_N);
  c_fifo_off:    cover property (FIFO_RESET ##1 !FIFO_ENABLE);
  c_dma_rx_mode: cover property (DMA_MODE && $fell(DMA_RX_REQ_N));
  c_read_alias:  cover property (s.bus == usc_pkg::BUS_READ && s.sel == usc_pkg::SEL_BREAK);
endmodule
`default_nettype wire

// File: tb/usc_remote_rx.sv
// usc_remote_rx: far end of the serial line, times how long the line sits at spacing
// assumes the line is sampled on MCLK; the line has no pull, the device always drives it
`timescale 1ns/1ps
`default_nettype none
module usc_remote_rx (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // serial line
  input  wire logic        line,
  output logic      [15:0] low_run
);
  // a spacing level held past a frame reads as break; saturate so a long break never wraps
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      low_run <= 16'h0000;
    else if (line)
      low_run <= 16'h0000;
    else if (low_run != 16'hFFFF)
      low_run <= low_run + 16'h0001;
  end
endmodule
`default_nettype wire

// File: tb/uart_shadow_control_regs_tb_top.sv
// uart_shadow_control_regs_tb_top: self-checking bench of the shadow control registers
// assumes usc_pkg compiled first; bench is the only AHB-Lite master, HREADY fed back from HREADYOUT
`timescale 1ns/1ps
`default_nettype none
module uart_shadow_control_regs_tb_top;
  localparam int D = 16;
  logic        mclk     = 1'b0;
  logic        arst_n   = 1'b0;
  logic        hsel     = 1'b0;
  logic [31:0] haddr    = 32'h0000_0000;
  logic [1:0]  htrans   = 2'h0;
  logic        hwrite   = 1'b0;
  logic [31:0] hwdata   = 32'h0000_0000;
  logic        tx_data  = 1'b1;
  logic [4:0]  rx_level = 5'h00;
  logic        tx_empty = 1'b0;
  logic        tx_full  = 1'b0;
  logic        hreadyout, hresp, tx_line, ir_tx_n, loop_rx, f_en, f_rst, dma_m, rx_av, rxq_n, txq_n, irq;
  logic [31:0] hrdata;
  logic [31:0] q;
  logic [15:0] low_run;
  int          err_total  = 0;
  int          num_checks = 0;

  initial
  begin
    forever #10 mclk = ~mclk;
  end

  usc_shadow_ctrl #(.DEPTH(D)) dut_u (.MCLK(mclk), .ARST_N(arst_n), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
    .HREADYOUT(hreadyout), .HRESP(hresp), .HRDATA(hrdata), .TX_DATA(tx_data), .TX_LINE(tx_line),
    .IR_TX_N(ir_tx_n), .LOOP_RX(loop_rx), .RX_LEVEL(rx_level), .TX_EMPTY(tx_empty), .TX_FULL(tx_full),
    .FIFO_ENABLE(f_en), .FIFO_RESET(f_rst), .DMA_MODE(dma_m), .RX_AVAIL(rx_av), .DMA_RX_REQ_N(rxq_n),
    .DMA_TX_REQ_N(txq_n), .IRQ(irq));

  usc_remote_rx far_u (.mclk(mclk), .arst_n(arst_n), .line(tx_line), .low_run(low_run));

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ready and read data are taken at the rising edge, before the design's update lands
  task automatic rdy;
    int n;
    n = 0;
    @(posedge mclk);
    while (hreadyout !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge mclk);
    end
    if (n == 50)
    begin
      err_total++;
      close_out;
    end
  endtask

  // address phase held until ready at an edge, then data phase held until ready again
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    q = hrdata;
  endtask

  task automatic wt(input int k);
    repeat (k) @(negedge mclk);
  endtask

  task automatic lvl(input int v);
    @(posedge mclk);
    rx_level <= 5'(v);
    wt(3);
  endtask

  task automatic t_reset;
    bus(0, usc_pkg::ADDR_BREAK, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    bus(0, usc_pkg::ADDR_DMA, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    bus(0, usc_pkg::ADDR_FEN, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    bus(0, usc_pkg::ADDR_TRIG, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    chk(32'({tx_line, ir_tx_n, loop_rx, irq, hresp}), 32'h0000_001C);
  endtask

  task automatic t_break;
    int n;
    bus(1, usc_pkg::ADDR_INT_MASK, 32'h0000_0001);
    bus(1, usc_pkg::ADDR_BREAK, 32'h0000_0001);
    bus(0, usc_pkg::ADDR_LCR, 32'h0000_0000);
    chk(q & 32'h0000_0040, 32'h0000_0040);
    bus(0, usc_pkg::ADDR_BREAK, 32'h0000_0000);
    chk(q, 32'h0000_0001);
    wt(20);
    chk(32'(tx_line), 32'h0000_0000);
    chk(32'(low_run > 16'h0014), 32'h0000_0001);
    chk(32'(irq), 32'h0000_0001);
    bus(1, usc_pkg::ADDR_INT_STATUS, 32'h0000_0001);
    wt(3);
    chk(32'(irq), 32'h0000_0000);
    bus(1, usc_pkg::ADDR_MCR, 32'h0000_0010);
    wt(3);
    chk(32'({tx_line, loop_rx}), 32'h0000_0002);
    bus(1, usc_pkg::ADDR_MCR, 32'h0000_0040);
    wt(3);
    n = 0;
    repeat (80)
    begin
      @(negedge mclk);
      n += 32'(!ir_tx_n);
    end
    chk(32'(n), 32'(usc_pkg::IR_LOW_CYC));
    bus(1, usc_pkg::ADDR_MCR, 32'h0000_0000);
    bus(1, usc_pkg::ADDR_BREAK, 32'h0000_0000);
    wt(3);
    chk(32'(tx_line), 32'h0000_0001);
  endtask

  task automatic t_fcr;
    bus(1, usc_pkg::ADDR_FCR, 32'h0000_00C9);
    bus(0, usc_pkg::ADDR_DMA, 32'h0000_0000);
    chk(q, 32'h0000_0001);
    bus(0, usc_pkg::ADDR_TRIG, 32'h0000_0000);
    chk(q, 32'h0000_0003);
    bus(1, usc_pkg::ADDR_DMA, 32'h0000_0000);
    bus(1, usc_pkg::ADDR_TRIG, 32'h0000_0001);
    bus(0, usc_pkg::ADDR_FCR, 32'h0000_0000);
    chk(q, 32'h0000_0041);
    chk(32'({f_en, dma_m}), 32'h0000_0002);
    bus(1, usc_pkg::ADDR_INT_STATUS, 32'h0000_0007);
    bus(1, usc_pkg::ADDR_FEN, 32'h0000_0000);
    wt(1);
    chk(32'(f_rst), 32'h0000_0001);
    wt(1);
    chk(32'(f_rst), 32'h0000_0000);
    bus(0, usc_pkg::ADDR_INT_STATUS, 32'h0000_0000);
    chk(q & 32'h0000_0002, 32'h0000_0002);
    bus(0, usc_pkg::ADDR_FCR, 32'h0000_0000);
    chk(q, 32'h0000_0040);
    chk(32'(f_en), 32'h0000_0000);
    // the two reset bits pulse the fifo reset and are not stored
    bus(1, usc_pkg::ADDR_FCR, 32'h0000_0046);
    wt(1);
    chk(32'(f_rst), 32'h0000_0001);
    bus(0, usc_pkg::ADDR_FCR, 32'h0000_0000);
    chk(q, 32'h0000_0040);
  endtask

  task automatic t_trig;
    int th;
    bus(1, usc_pkg::ADDR_FEN, 32'h0000_0001);
    for (int t = 0; t < 4; t++)
    begin
      bus(1, usc_pkg::ADDR_TRIG, 32'(t));
      bus(0, usc_pkg::ADDR_FCR, 32'h0000_0000);
      chk(q >> 6, 32'(t));
      th = t == 0 ? 1 : t == 1 ? D / 4 : t == 2 ? D / 2 : D - 2;
      lvl(th - 1);
      chk(32'(rx_av), 32'h0000_0000);
      lvl(th);
      chk(32'(rx_av), 32'h0000_0001);
    end
  endtask

  // mode 1 request holds from trigger down to empty, so a level between must keep it
  task automatic t_dma;
    bus(1, usc_pkg::ADDR_DMA, 32'h0000_0001);
    bus(1, usc_pkg::ADDR_TRIG, 32'h0000_0002);
    lvl(0);
    chk(32'(rxq_n), 32'h0000_0001);
    lvl(D / 2 - 1);
    chk(32'(rxq_n), 32'h0000_0001);
    lvl(D / 2);
    chk(32'(rxq_n), 32'h0000_0000);
    lvl(3);
    chk(32'(rxq_n), 32'h0000_0000);
    lvl(0);
    chk(32'(rxq_n), 32'h0000_0001);
    bus(1, usc_pkg::ADDR_DMA, 32'h0000_0000);
    tx_empty <= 1'b1;
    lvl(1);
    chk(32'({rxq_n, txq_n, dma_m}), 32'h0000_0000);
    // mode 1 transmit request holds from empty until full
    bus(1, usc_pkg::ADDR_DMA, 32'h0000_0001);
    tx_empty <= 1'b0;
    wt(3);
    chk(32'(txq_n), 32'h0000_0000);
    tx_full <= 1'b1;
    wt(3);
    chk(32'(txq_n), 32'h0000_0001);
  endtask

  task automatic t_unmap;
    bus(1, 32'h5000_10A0, 32'hFFFF_FFFF);
    bus(0, 32'h5000_10A0, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    bus(1, usc_pkg::ADDR_TRIG, 32'hFFFF_FFFF);
    bus(0, usc_pkg::ADDR_TRIG, 32'h0000_0000);
    chk(q, 32'h0000_0003);
  endtask

  initial
  begin
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    t_reset;
    t_break;
    t_fcr;
    t_trig;
    t_dma;
    t_unmap;
    close_out;
  end
endmodule
`default_nettype wire
